// file: src/cisc_input_seq.sv
// input sequence control: channel/start select, step pointer, results
// assumes strobe, search result and reset inputs synchronous to mclk
`timescale 1ns/1ns
`include "cisc_consts.svh"
module cisc_input_seq
	import cisc_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// host pins
	input wire logic writeStrobe,
	input wire logic pointerResetPinN,
	input wire logic channelSelectPin,
	input wire logic deviceIdSubmode,
	input wire logic idPriority,
	// search engine
	input wire cisc_result_t searchResult,
	output logic [3:0] stepEntrySel,
	output logic searchFire,
	output logic searchHead,
	output logic captureFire,
	// result pins
	output logic hitPinN,
	output logic multiHitPinN,
	output logic stepResult0Out,
	output logic stepResult0Oe,
	output logic stepResult1Out,
	output logic stepResult1Oe,
	output logic busyActivePinN
);
	// ****************************************
	// registers
	// ****************************************
	logic [8:0] ctrl_reg;
	logic activeCh_reg;
	logic [2:0] ptr_reg;
	logic [2:0] startStep_reg;
	logic [2:0] doneStep_reg;
	logic [7:0] ssA_reg, ssB_reg, cutA_reg, cutB_reg;
	logic [1:0] cfgA_reg [0:7];
	logic [1:0] cfgB_reg [0:7];
	logic [7:0] shAsgn_reg;
	logic [2:0] pos_reg;
	logic [31:0] key_reg [0:7];
	logic strobe_reg;
	logic andAcc_reg;
	cisc_state_t state_reg;
	logic lastHit_reg, lastMulti_reg;
	logic sh0Hit_reg, sh1Hit_reg;
	logic seqOpen, captureNow;

	// ****************************************
	// decode functions
	// ****************************************
	function automatic logic isAddr(input logic [11:0] a, input logic [11:0] o);
		isAddr = (a == o);
	endfunction

	// step result pin assignment: {channel, step} nibble
	function automatic logic stepMatch(input logic [3:0] asg,
		input logic ch, input logic [2:0] p);
		stepMatch = (asg == {ch, p});
	endfunction

	logic apbWr, apbRd, cmdReset, ptrReset;
	logic riseEdge, fallEdge, firstEdge, secondEdge;
	logic [7:0] ssCur, cutCur;
	logic [1:0] cfgCur;
	logic stepNow, endNow, combHit;
	assign apbWr = psel && penable && pwrite;
	assign apbRd = psel && penable && !pwrite;
	assign cmdReset = apbWr && isAddr(paddr, `CISC_OFS_CMD)
		&& pwdata[`CISC_CMD_PTRRST_BIT];
	assign ptrReset = !pointerResetPinN || cmdReset;

	// ****************************************
	// strobe edges and step decode
	// ****************************************
	assign riseEdge = writeStrobe && !strobe_reg;
	assign fallEdge = !writeStrobe && strobe_reg;
	assign firstEdge = ctrl_reg[`CISC_CTRL_STRB_POL_BIT] ? riseEdge : fallEdge;
	assign secondEdge = ctrl_reg[`CISC_CTRL_STRB_POL_BIT] ? fallEdge : riseEdge;
	assign ssCur = activeCh_reg ? ssB_reg : ssA_reg;
	assign cutCur = activeCh_reg ? cutB_reg : cutA_reg;
	assign cfgCur = activeCh_reg ? cfgB_reg[ptr_reg] : cfgA_reg[ptr_reg];
	assign seqOpen = !ptrReset && state_reg != CISC_DONE
		&& state_reg != CISC_LAST;
	assign stepNow = firstEdge && seqOpen && ssCur[pos_reg];
	assign captureNow = firstEdge && seqOpen && cutCur[pos_reg];
	assign endNow = stepNow && cfgCur[`CISC_CFG_EOS_BIT];
	assign combHit = searchResult.hit
		&& (cfgCur[`CISC_CFG_HEAD_BIT] || andAcc_reg);

	// ****************************************
	// control register and configuration
	// ****************************************
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			ctrl_reg <= 9'h000;
			ssA_reg <= 8'h00;
			ssB_reg <= 8'h00;
			cutA_reg <= 8'h00;
			cutB_reg <= 8'h00;
			shAsgn_reg <= `CISC_SHASGN_RESET;
		end else if (apbWr) begin
			if (isAddr(paddr, `CISC_OFS_CTRL))
				ctrl_reg <= pwdata[8:0];
			if (isAddr(paddr, `CISC_OFS_SSREG)) begin
				ssA_reg <= pwdata[7:0];
				ssB_reg <= pwdata[15:8];
			end
			if (isAddr(paddr, `CISC_OFS_CUTREG)) begin
				cutA_reg <= pwdata[7:0];
				cutB_reg <= pwdata[15:8];
			end
			if (isAddr(paddr, `CISC_OFS_SHASGN))
				shAsgn_reg <= pwdata[7:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			for (int i = 0; i < 8; i++) begin
				cfgA_reg[i] <= 2'h0;
				cfgB_reg[i] <= 2'h0;
			end
		end else if (apbWr && isAddr(paddr, `CISC_OFS_SEQCFG)) begin
			for (int i = 0; i < 8; i++) begin
				cfgA_reg[i] <= pwdata[2*i +: 2];
				cfgB_reg[i] <= pwdata[16 + 2*i +: 2];
			end
		end
	end

	// ****************************************
	// channel and start step latch
	// ****************************************
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			activeCh_reg <= 1'b0;
			startStep_reg <= 3'h0;
		end else if (ptrReset) begin
			activeCh_reg <= ctrl_reg[`CISC_CTRL_IAS_BIT] ? channelSelectPin
				: ctrl_reg[`CISC_CTRL_CH_LSB];
			startStep_reg <= ctrl_reg[`CISC_CTRL_IPN_LSB +: 3];
		end
	end

	// ****************************************
	// sequencer
	// ****************************************
	always_ff @(posedge mclk) begin
		if (!rstn)
			strobe_reg <= 1'b1; // idle level of negative strobe
		else
			strobe_reg <= writeStrobe;
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			state_reg <= CISC_IDLE;
			ptr_reg <= 3'h0;
			pos_reg <= 3'h0;
			doneStep_reg <= 3'h0;
			andAcc_reg <= 1'b0;
		end else if (ptrReset) begin
			state_reg <= CISC_IDLE;
			ptr_reg <= ctrl_reg[`CISC_CTRL_IPN_LSB +: 3];
			pos_reg <= 3'h0;
		end else begin
			case (state_reg)
			CISC_IDLE, CISC_RUN: begin
				if (firstEdge) begin
					state_reg <= CISC_RUN;
					pos_reg <= pos_reg + 3'h1;
					if (endNow)
						state_reg <= CISC_LAST;
					if (stepNow) begin
						ptr_reg <= endNow ? ptr_reg : ptr_reg + 3'h1;
						doneStep_reg <= ptr_reg;
						andAcc_reg <= combHit;
					end
				end
			end
			CISC_LAST: begin
				if (secondEdge)
					state_reg <= CISC_DONE;
			end
			CISC_DONE: state_reg <= CISC_DONE;
			default: state_reg <= CISC_IDLE;
			endcase
		end
	end

	// ****************************************
	// search engine strobes
	// ****************************************
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			searchFire <= 1'b0;
			captureFire <= 1'b0;
			stepEntrySel <= 4'h0;
			searchHead <= 1'b0;
		end else begin
			searchFire <= stepNow;
			captureFire <= captureNow;
			stepEntrySel <= {activeCh_reg, ptr_reg};
			searchHead <= cfgCur[`CISC_CFG_HEAD_BIT];
		end
	end

	// ****************************************
	// hit and multi-hit result pins
	// ****************************************
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			hitPinN <= 1'b1;
			lastHit_reg <= 1'b0;
			lastMulti_reg <= 1'b0;
		end else if (stepNow) begin
			hitPinN <= !searchResult.hit;
			lastHit_reg <= searchResult.hit;
			lastMulti_reg <= searchResult.multiHit;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn)
			multiHitPinN <= 1'b1;
		else
			multiHitPinN <= deviceIdSubmode ? idPriority
				: !(stepNow ? searchResult.multiHit : lastMulti_reg);
	end

	// ****************************************
	// step result pins
	// ****************************************

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			sh0Hit_reg <= 1'b0;
			sh1Hit_reg <= 1'b0;
		end else if (ptrReset) begin
			sh0Hit_reg <= 1'b0;
			sh1Hit_reg <= 1'b0;
		end else if (stepNow) begin
			if (stepMatch(shAsgn_reg[3:0], activeCh_reg, ptr_reg))
				sh0Hit_reg <= combHit;
			if (stepMatch(shAsgn_reg[7:4], activeCh_reg, ptr_reg))
				sh1Hit_reg <= combHit;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			stepResult0Out <= 1'b0;
			stepResult1Out <= 1'b0;
			stepResult0Oe <= 1'b0;
			stepResult1Oe <= 1'b0;
		end else begin
			stepResult0Out <= 1'b0;
			stepResult1Out <= 1'b0;
			stepResult0Oe <= sh0Hit_reg && !ptrReset;
			stepResult1Oe <= sh1Hit_reg && !ptrReset;
		end
	end

	// ****************************************
	// key store
	// ****************************************
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			for (int i = 0; i < 8; i++)
				key_reg[i] <= 32'h0000_0000;
		end else if (stepNow) begin
			key_reg[ptr_reg] <= searchResult.key;
		end
	end

	// ****************************************
	// busy/active pin
	// ****************************************
	always_ff @(posedge mclk) begin
		if (!rstn)
			busyActivePinN <= 1'b1;
		else if (ptrReset)
			busyActivePinN <= 1'b1;
		else if (state_reg == CISC_IDLE && firstEdge && !endNow)
			busyActivePinN <= 1'b0;
		else if (endNow && ctrl_reg[`CISC_CTRL_BUSY_BIT])
			busyActivePinN <= 1'b1;
		else if (state_reg == CISC_IDLE && firstEdge)
			busyActivePinN <= 1'b0;
		else if (state_reg == CISC_LAST && secondEdge)
			busyActivePinN <= 1'b1;
	end

	// ****************************************
	// apb read path
	// ****************************************
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			if (psel && !penable && !pwrite) begin
				case (paddr)
				`CISC_OFS_CTRL: prdata <= {23'h0, ctrl_reg[8:7],
					startStep_reg, ctrl_reg[3], 2'h0, activeCh_reg};
				`CISC_OFS_DSTAT: prdata <= {28'h0, doneStep_reg,
					busyActivePinN};
				`CISC_OFS_HIT_STATUS_REGISTER: prdata <= {28'h0, lastMulti_reg,
					lastHit_reg, 1'b0, activeCh_reg};
				`CISC_OFS_ERROR_STATUS_REGISTER: prdata <= {31'h0, activeCh_reg};
				`CISC_OFS_SSREG: prdata <= {16'h0, ssB_reg, ssA_reg};
				`CISC_OFS_CUTREG: prdata <= {16'h0, cutB_reg, cutA_reg};
				`CISC_OFS_SHASGN: prdata <= {24'h0, shAsgn_reg};
				default: begin
					if (paddr[11:5] == 7'h02)
						prdata <= key_reg[paddr[4:2]];
					else if (!isAddr(paddr, `CISC_OFS_SEQCFG)
						&& !isAddr(paddr, `CISC_OFS_CMD))
						pslverr <= 1'b1;
				end
				endcase
			end else if (psel && !penable && pwrite) begin
				pslverr <= !(isAddr(paddr, `CISC_OFS_CTRL)
					|| isAddr(paddr, `CISC_OFS_SSREG)
					|| isAddr(paddr, `CISC_OFS_CUTREG)
					|| isAddr(paddr, `CISC_OFS_SHASGN)
					|| isAddr(paddr, `CISC_OFS_SEQCFG)
					|| isAddr(paddr, `CISC_OFS_CMD));
			end
		end
	end
endmodule

// file: src/cisc_consts.svh
// constants for the input sequence control block
// assumes APB register map with word-aligned byte offsets
`ifndef CISC_CONSTS_SVH
`define CISC_CONSTS_SVH
`define CISC_OFS_CTRL 12'h000
`define CISC_OFS_DSTAT 12'h004
`define CISC_OFS_HIT_STATUS_REGISTER 12'h008
`define CISC_OFS_ERROR_STATUS_REGISTER 12'h00C
`define CISC_OFS_SEQCFG 12'h010
`define CISC_OFS_SSREG 12'h014
`define CISC_OFS_CUTREG 12'h018
`define CISC_OFS_SHASGN 12'h01C
`define CISC_OFS_CMD 12'h020
`define CISC_OFS_KEY0 12'h040
`define CISC_CTRL_CH_LSB 0
`define CISC_CTRL_IAS_BIT 3
`define CISC_CTRL_IPN_LSB 4
`define CISC_CTRL_BUSY_BIT 7
`define CISC_CTRL_STRB_POL_BIT 8
`define CISC_CTRL_RESET 32'h0000_0000
`define CISC_CMD_PTRRST_BIT 0
`define CISC_CFG_EOS_BIT 0
`define CISC_CFG_HEAD_BIT 1
`define CISC_SHASGN_RESET 8'h00
`endif

// file: src/cisc_pkg.sv
// types for the input sequence control block
// assumes cisc_consts.svh is on the include path
package cisc_pkg;
	typedef enum logic [1:0] {CISC_IDLE, CISC_RUN, CISC_LAST, CISC_DONE}
		cisc_state_t;
	typedef struct packed {
		logic hit;
		logic multiHit;
		logic [31:0] key;
	} cisc_result_t;
endpackage

// file: testbench/cisc_input_seq_sva.sv
// port checker for the input sequence control block
// assumes a bind from the bench top onto cisc_input_seq
`timescale 1ns/1ns
module cisc_input_seq_sva(
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// inputs
	input wire logic psel,
	input wire logic penable,
	input wire logic writeStrobe,
	input wire logic pointerResetPinN,
	input wire logic deviceIdSubmode,
	input wire logic idPriority,
	// outputs
	input wire logic pready,
	input wire logic pslverr,
	input wire logic searchFire,
	input wire logic hitPinN,
	input wire logic multiHitPinN,
	input wire logic stepResult0Out,
	input wire logic stepResult0Oe,
	input wire logic stepResult1Out,
	input wire logic stepResult1Oe,
	input wire logic busyActivePinN
);
	// ****
	// properties
	// ****
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	a_reset_idle: assert property ($rose(rstn) |-> busyActivePinN && hitPinN && !pready)
		else $error("outputs not idle after reset");
	a_drain_only: assert property (!stepResult0Out && !stepResult1Out)
		else $error("step result pin driven high");
	a_ptr_float: assert property (!pointerResetPinN |=> !stepResult0Oe && !stepResult1Oe)
		else $error("step result pin not released");
	a_hit_hold: assert property (!pointerResetPinN && !searchFire |=> $stable(hitPinN))
		else $error("hit pin moved on pointer reset");
	a_id_priority: assert property ($past(deviceIdSubmode) |-> multiHitPinN == $past(idPriority))
		else $error("priority not on multi-hit pin");
	a_busy_start: assert property ($fell(busyActivePinN) |-> $past(writeStrobe) != $past(writeStrobe, 2))
		else $error("busy fell without strobe edge");
	a_fire_edge: assert property (searchFire |-> $past(writeStrobe) != $past(writeStrobe, 2))
		else $error("search without strobe edge");
	a_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("ready not in access cycle");
	a_apb_err: assert property (pslverr |-> pready)
		else $error("error without ready");
	c_fire: cover property (searchFire);
	c_ptr: cover property (!pointerResetPinN);
	c_err: cover property (pslverr);
endmodule

// file: testbench/cisc_host_model.sv
// host model: write strobes, pointer reset pulses, channel pin
// assumes tasks are called right after a rising edge of mclk
`timescale 1ns/1ns
module cisc_host_model(
	// clock
	input wire logic mclk,
	// host pins
	output logic writeStrobe,
	output logic pointerResetPinN,
	output logic channelSelectPin
);
	// ****
	// host pins
	// ****
	initial begin
		writeStrobe = 1'h1;
		pointerResetPinN = 1'h1;
		channelSelectPin = 1'h0;
	end
	// low pulse after control writes; channel pin flips afterwards
	task ptr_reset(input logic pin);
		channelSelectPin <= pin;
		pointerResetPinN <= 1'h0;
		@(posedge mclk);
		pointerResetPinN <= 1'h1;
		@(posedge mclk);
		channelSelectPin <= ~pin;
		repeat (2) @(posedge mclk);
	endtask
	// negative strobe: low two cycles, high two cycles
	task strobe;
		writeStrobe <= 1'h0;
		repeat (2) @(posedge mclk);
		writeStrobe <= 1'h1;
		repeat (2) @(posedge mclk);
	endtask
endmodule

// file: testbench/test_cisc_input_seq.sv
// self-checking bench for the input sequence control block
// assumes host model and checker compile first
`timescale 1ns/1ns
module test_cisc_input_seq;
	import cisc_pkg::*;
	// ****
	// signals
	// ****
	logic mclk, rstn, psel, penable, pwrite, pready, pslverr, searchFire;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic writeStrobe, pointerResetPinN, channelSelectPin, deviceIdSubmode;
	logic idPriority, hitPinN, multiHitPinN, busyActivePinN, qe;
	logic stepResult0Out, stepResult0Oe, stepResult1Out, stepResult1Oe;
	logic searchHead, captureFire;
	logic [3:0] stepEntrySel;
	cisc_result_t searchResult;
	int err_total, checked, fires, caps;
	cisc_input_seq dut(.*);
	cisc_host_model host(.*);
	initial begin
		mclk = 1'h0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) if (searchFire === 1'h1) fires++;
	always @(posedge mclk) if (captureFire === 1'h1) caps++;
	// ****
	// tasks
	// ****
	task stop_test;
		$display("mismatches %0d comparisons %0d", err_total, checked);
		if (err_total == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'h1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		if (n >= 20) begin
			err_total++;
			stop_test;
		end
		q = prdata;
		qe = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge mclk);
	endtask
	task rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'h0, a, 32'h0);
		check(q & m, e);
	endtask
	task t_reset;
		rd(12'h000, 32'hFFFFFFFF, 32'h0);
		rd(12'h004, 32'h1, 32'h1);
		apb(1'h0, 12'hFFC, 32'h0);
		check({31'h0, qe}, 32'h1);
	endtask
	task t_channel;
		apb(1'h1, 12'h000, 32'h1);
		rd(12'h000, 32'h1, 32'h0);
		host.ptr_reset(1'h0);
		rd(12'h000, 32'h1, 32'h1);
		rd(12'h008, 32'h1, 32'h1);
		rd(12'h00C, 32'h1, 32'h1);
		apb(1'h1, 12'h000, 32'h9);
		host.ptr_reset(1'h0);
		rd(12'h000, 32'h1, 32'h0);
		host.ptr_reset(1'h1);
		rd(12'h000, 32'h1, 32'h1);
	endtask
	task t_sequence;
		apb(1'h1, 12'h000, 32'h50);
		host.ptr_reset(1'h0);
		rd(12'h000, 32'h71, 32'h50);
		check({28'h0, stepEntrySel}, 32'h5);
		apb(1'h1, 12'h014, 32'h5);
		apb(1'h1, 12'h018, 32'h5);
		apb(1'h1, 12'h010, 32'h3800);
		apb(1'h1, 12'h01C, 32'h65);
		apb(1'h1, 12'h020, 32'h1);
		searchResult <= {1'h1, 1'h1, 32'hA5A50005};
		host.strobe;
		check({hitPinN, multiHitPinN, stepResult0Oe, busyActivePinN}, 4'h2);
		searchResult <= {1'h0, 1'h0, 32'h5A5A0006};
		host.strobe;
		check(fires, 1);
		host.strobe;
		check({hitPinN, stepResult0Oe, stepResult1Oe, busyActivePinN}, 4'hD);
		rd(12'h004, 32'hE, 32'hC);
		rd(12'h054, 32'hFFFFFFFF, 32'hA5A50005);
		rd(12'h058, 32'hFFFFFFFF, 32'h5A5A0006);
		host.strobe;
		check(fires, 2);
		check(caps, 2);
		host.ptr_reset(1'h0);
		check({hitPinN, stepResult0Oe}, 2'h2);
	endtask
	task t_priority;
		deviceIdSubmode <= 1'h1;
		repeat (2) @(posedge mclk);
		check(multiHitPinN, 1'h0);
		idPriority <= 1'h1;
		repeat (2) @(posedge mclk);
		check(multiHitPinN, 1'h1);
	endtask
	// ****
	// main sequence
	// ****
	initial begin
		{rstn, psel, penable, pwrite, paddr, pwdata} = '0;
		{deviceIdSubmode, idPriority, searchResult} = '0;
		repeat (10) @(posedge mclk);
		rstn <= 1'h1;
		@(posedge mclk);
		t_reset;
		t_channel;
		t_sequence;
		t_priority;
		stop_test;
	end
	initial begin
		repeat (100000) @(posedge mclk);
		err_total++;
		stop_test;
	end
endmodule
bind cisc_input_seq cisc_input_seq_sva chk(.*);
